// *** ppw_checker.sv ***
// Purpose: concurrent checks on the port pin wake-up block
// Assumes: one clock, synchronous active-low reset
// Notes: sees only top-level ports, bound at the foot
`timescale 1ns/1ps
`default_nettype none

module ppw_checker (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // sleep handshake
    input wire logic sleep_active,
    input wire logic wake_req,
    // pads
    input wire logic [7:0] pa_pad_out,
    input wire logic [7:0] pa_pad_oe,
    input wire logic [7:0] pa_pull_up,
    input wire logic [7:0] pa_in_en,
    input wire logic [7:0] pb_pad_oe,
    input wire logic [7:0] pb_pull_up,
    input wire logic [7:0] pb_pull_dn,
    input wire logic [7:0] pb_in_en,
    // register bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////
    // named events: one-cycle write handshake, multi-step reset release
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rst_rel;
        !aresetn ##1 aresetn [*2];
    endsequence

    ////////////////////////////////////////////////////////////////
    rstpin_no_high_a: assert property (pa_pad_out[5] == 1'b0)
        else $error("reset-shared pin drives high");
    pull_vs_out_a: assert property (
        ((pa_pad_oe & pa_pull_up) | (pb_pad_oe & pb_pull_up)) == 8'h00)
        else $error("pull-high on with output driven");
    pulldn_pins_a: assert property (
        ((pb_pull_dn & 8'h3f) | (pb_pad_oe & pb_pull_dn)) == 8'h00)
        else $error("pull-low on a wrong pin");
    // checked whatever the reset state, hence no disable
    rst_die_a: assert property (disable iff (1'b0)
        rst_rel |=> pa_in_en == 8'hf9 && pb_in_en == 8'hff)
        else $error("input enables not set after reset");
    wake_drop_a: assert property ($fell(sleep_active) |=> !wake_req)
        else $error("wake request outlives sleep");
    wake_cause_a: assert property ($rose(wake_req) |-> $past(sleep_active))
        else $error("wake request outside sleep");
    // response registered one edge after the write fires
    wr_answer_a: assert property (wr_take |=> !s_axi_awready ##1 s_axi_bvalid)
        else $error("write response missing");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response missing");
endmodule

bind ppw_top ppw_checker u_chk (.aclk(aclk), .aresetn(aresetn), .sleep_active(sleep_active),
    .wake_req(wake_req), .pa_pad_out(pa_pad_out), .pa_pad_oe(pa_pad_oe),
    .pa_pull_up(pa_pull_up), .pa_in_en(pa_in_en), .pb_pad_oe(pb_pad_oe),
    .pb_pull_up(pb_pull_up), .pb_pull_dn(pb_pull_dn), .pb_in_en(pb_in_en),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));
`default_nettype wire

// *** ppw_edge.v ***
// Purpose: per-line edge detector with selectable polarity
// Assumes: input already synchronised
// Notes: pulse is one cycle wide
`timescale 1ns/1ps
`default_nettype none

module ppw_edge (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // level and mode
    input wire level,
    input wire [1:0] mode,
    output wire pulse
);

reg prev_reg;

// remember last level
always @(posedge aclk)
begin
    if (!aresetn)
        prev_reg <= 1'b0;
    else
        prev_reg <= level;
end

// mode bit 0 rising, bit 1 falling
assign pulse = (mode[0] & level & ~prev_reg) | (mode[1] & ~level & prev_reg);

endmodule
`default_nettype wire

// *** ppw_pads.sv ***
// Purpose: board-side model of one 8-bit port's pads
// Assumes: outside circuit drives where ext_en is set
// Notes: a pin nobody drives or pulls toggles every cycle
`timescale 1ns/1ps
`default_nettype none

module ppw_pads (
    // clock
    input wire logic aclk,
    // design side
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pull_up,
    input wire logic [7:0] pull_dn,
    // outside circuit
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    // resolved level
    output logic [7:0] pad_in
);
    logic tgl = 1'b0;
    int i;

    // floating level must not look like a stable value
    always @(posedge aclk)
        tgl <= ~tgl;

    // device drive wins, then outside drive, then pulls
    always @*
        for (i = 0; i < 8; i++)
            pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                pull_up[i] ? 1'b1 : pull_dn[i] ? 1'b0 : tgl;
endmodule
`default_nettype wire

// *** ppw_regs.vh ***
// Purpose: register map and field constants for the port pin wake-up block
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes: all offsets are byte addresses
`ifndef PPW_REGS_VH
`define PPW_REGS_VH

`define PPW_PA_DATA_OFF 8'h00
`define PPW_PA_DIR_OFF 8'h04
`define PPW_PA_PULLUP_OFF 8'h08
`define PPW_PA_DIE_OFF 8'h0c
`define PPW_PA_IN_OFF 8'h10
`define PPW_PB_DATA_OFF 8'h14
`define PPW_PB_DIR_OFF 8'h18
`define PPW_PB_PULLUP_OFF 8'h1c
`define PPW_PB_PULLDN_OFF 8'h20
`define PPW_PB_DIE_OFF 8'h24
`define PPW_PB_IN_OFF 8'h28
`define PPW_WAKE_CFG_OFF 8'h2c
`define PPW_IRQ_CFG_OFF 8'h30
`define PPW_IRQ_STAT_OFF 8'h34
`define PPW_IRQ_MASK_OFF 8'h38

`define PPW_DIE_RST 8'hff
`define PPW_ZERO_RST 8'h00
// port bit that shares the external reset
`define PPW_RSTPIN_BIT 5
// pins with pull-low resistor: port b bits 6 and 7
`define PPW_PB_PULLDN_MASK 8'hc0
// irq_cfg fields: [1:0] line0 edge, [3:2] line1 edge
`define PPW_EDGE_RISE 2'b01
`define PPW_EDGE_FALL 2'b10
`define PPW_EDGE_BOTH 2'b11
// irq status bits
`define PPW_ST_EXT0 0
`define PPW_ST_EXT1 1
`define PPW_ST_WAKE 2
// fast wake settle ticks, normal wake settle ticks
`define PPW_WAKE_FAST_CYC 16'd16
`define PPW_WAKE_NORM_CYC 16'd2048

`endif

// *** ppw_sync.v ***
// Purpose: three-flop synchroniser with agreement filter for pin inputs
// Assumes: one clock, aclk
// Notes: output changes once second and third stages agree
`timescale 1ns/1ps
`default_nettype none

module ppw_sync #(
    parameter W = 8
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // data
    input wire [W-1:0] d_in,
    output reg [W-1:0] q_out
);

reg [W-1:0] s1_reg;
reg [W-1:0] s2_reg;
reg [W-1:0] s3_reg;

// first stage read only by second; filter looks at stages two and three
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s1_reg <= {W{1'b0}};
        s2_reg <= {W{1'b0}};
        s3_reg <= {W{1'b0}};
        q_out <= {W{1'b0}};
    end
    else
    begin
        s1_reg <= d_in;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        q_out <= (q_out & (s2_reg ^ s3_reg)) | (s2_reg & s3_reg);
    end
end

endmodule
`default_nettype wire

// *** ppw_top.v ***
// Purpose: port a / port b pin logic with wake-up and external interrupts
// Assumes: AXI4-Lite slave, 125 MHz aclk, pad cells outside
// Notes: pins with input disabled read zero and cannot wake
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ppw_regs.vh"

module ppw_top #(
    parameter PA_W = 8,
    parameter PB_W = 8,
    parameter [PA_W-1:0] PA_IMPL = 8'hf9,
    parameter [PB_W-1:0] PB_IMPL = 8'hff,
    parameter [15:0] WAKE_NORM_CYC = `PPW_WAKE_NORM_CYC,
    parameter [15:0] WAKE_FAST_CYC = `PPW_WAKE_FAST_CYC
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // code options, held static
    input wire irq0_alt_sel,
    input wire irq1_alt_sel,
    // sleep handshake
    input wire sleep_active,
    output reg wake_req,
    // pads of port a
    input wire [PA_W-1:0] pa_pad_in,
    output reg [PA_W-1:0] pa_pad_out,
    output reg [PA_W-1:0] pa_pad_oe,
    output reg [PA_W-1:0] pa_pull_up,
    output reg [PA_W-1:0] pa_in_en,
    // pads of port b
    input wire [PB_W-1:0] pb_pad_in,
    output reg [PB_W-1:0] pb_pad_out,
    output reg [PB_W-1:0] pb_pad_oe,
    output reg [PB_W-1:0] pb_pull_up,
    output reg [PB_W-1:0] pb_pull_dn,
    output reg [PB_W-1:0] pb_in_en,
    // interrupt
    output reg irq,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

localparam [1:0] RESP_OK = 2'b00;
localparam [1:0] RESP_SLVERR = 2'b10;
localparam [1:0] WK_IDLE = 2'b00;
localparam [1:0] WK_SETTLE = 2'b01;
localparam [1:0] WK_HOLD = 2'b10;

////////////////////////////////////////////////////////////////////////////////
// registers

reg [7:0] pa_data_reg;
reg [7:0] pa_dir_reg;
reg [7:0] pa_pullup_reg;
reg [7:0] pa_die_reg;
reg [7:0] pb_data_reg;
reg [7:0] pb_dir_reg;
reg [7:0] pb_pullup_reg;
reg [7:0] pb_pulldn_reg;
reg [7:0] pb_die_reg;
reg [1:0] wake_cfg_reg;
reg [3:0] irq_cfg_reg;
reg [2:0] irq_stat_reg;
reg [2:0] irq_mask_reg;
reg [7:0] aw_addr_reg;
reg aw_have_reg;
reg [31:0] w_data_reg;
reg [3:0] w_strb_reg;
reg w_have_reg;

wire [PA_W-1:0] pa_sync;
wire [PB_W-1:0] pb_sync;
wire [PA_W-1:0] pa_gated;
wire [PB_W-1:0] pb_gated;
reg [PA_W-1:0] pa_prev_reg;
reg [PB_W-1:0] pb_prev_reg;
wire irq0_level;
wire irq1_level;
wire irq0_pulse;
wire irq1_pulse;
wire pin_toggle;
wire wr_fire;
wire [7:0] wr_byte;
reg [2:0] stat_set;

// byte-lane merge of a write into an 8-bit register
function [7:0] lane0;
    input [7:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
        lane0 = strb[0] ? data[7:0] : old;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// pin input path

ppw_sync #(.W(PA_W)) u_sync_pa (
    .aclk(aclk),
    .aresetn(aresetn),
    .d_in(pa_pad_in),
    .q_out(pa_sync)
);

ppw_sync #(.W(PB_W)) u_sync_pb (
    .aclk(aclk),
    .aresetn(aresetn),
    .d_in(pb_pad_in),
    .q_out(pb_sync)
);

assign pa_gated = pa_sync & pa_die_reg & PA_IMPL;
assign pb_gated = pb_sync & pb_die_reg & PB_IMPL;

assign irq0_level = irq0_alt_sel ? pb_gated[5] : pa_gated[0];
assign irq1_level = irq1_alt_sel ? pa_gated[4] : pb_gated[0];

ppw_edge u_edge0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(irq0_level),
    .mode(irq_cfg_reg[1:0]),
    .pulse(irq0_pulse)
);

ppw_edge u_edge1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(irq1_level),
    .mode(irq_cfg_reg[3:2]),
    .pulse(irq1_pulse)
);

// disabled pins cannot toggle here since gated value sits at zero
assign pin_toggle = (|(pa_gated ^ pa_prev_reg)) | (|(pb_gated ^ pb_prev_reg));

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        pa_prev_reg <= {PA_W{1'b0}};
        pb_prev_reg <= {PB_W{1'b0}};
    end
    else
    begin
        pa_prev_reg <= pa_gated;
        pb_prev_reg <= pb_gated;
    end
end

////////////////////////////////////////////////////////////////////////////////
// wake sequencer: normal or fast settle before wake request

reg [1:0] wk_state_reg;
reg [15:0] wk_cnt_reg;

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        wk_state_reg <= WK_IDLE;
        wk_cnt_reg <= 16'h0000;
        wake_req <= 1'b0;
    end
    else
    begin
        case (wk_state_reg)
            WK_IDLE:
            begin
                wake_req <= 1'b0;
                if (sleep_active && wake_cfg_reg[0] && pin_toggle)
                begin
                    wk_cnt_reg <= wake_cfg_reg[1] ? WAKE_FAST_CYC : WAKE_NORM_CYC;
                    wk_state_reg <= WK_SETTLE;
                end
            end
            WK_SETTLE:
            begin
                if (wk_cnt_reg <= 16'h0001)
                begin
                    wake_req <= 1'b1;
                    wk_state_reg <= WK_HOLD;
                end
                else
                    wk_cnt_reg <= wk_cnt_reg - 16'h0001;
            end
            WK_HOLD:
            begin
                // held until the core leaves sleep
                if (!sleep_active)
                begin
                    wake_req <= 1'b0;
                    wk_state_reg <= WK_IDLE;
                end
            end
            default:
                wk_state_reg <= WK_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite write channel; address and data may arrive in either order

assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
assign wr_byte = lane0(8'h00, w_data_reg, w_strb_reg);

always @(*)
begin
    stat_set = 3'b000;
    stat_set[`PPW_ST_EXT0] = irq0_pulse;
    stat_set[`PPW_ST_EXT1] = irq1_pulse;
    stat_set[`PPW_ST_WAKE] = (wk_state_reg == WK_SETTLE) && (wk_cnt_reg <= 16'h0001);
end

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= RESP_OK;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        aw_addr_reg <= 8'h00;
        w_data_reg <= 32'h00000000;
        w_strb_reg <= 4'h0;
        pa_data_reg <= `PPW_ZERO_RST;
        pa_dir_reg <= `PPW_ZERO_RST;
        pa_pullup_reg <= `PPW_ZERO_RST;
        pa_die_reg <= `PPW_DIE_RST;
        pb_data_reg <= `PPW_ZERO_RST;
        pb_dir_reg <= `PPW_ZERO_RST;
        pb_pullup_reg <= `PPW_ZERO_RST;
        pb_pulldn_reg <= `PPW_ZERO_RST;
        pb_die_reg <= `PPW_DIE_RST;
        wake_cfg_reg <= 2'b00;
        irq_cfg_reg <= 4'h0;
        irq_stat_reg <= 3'b000;
        irq_mask_reg <= 3'b000;
    end
    else
    begin
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_addr_reg <= s_axi_awaddr;
            aw_have_reg <= 1'b1;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            w_have_reg <= 1'b1;
            s_axi_wready <= 1'b0;
        end
        // sticky status; set wins over write-one-clear
        irq_stat_reg <= irq_stat_reg | stat_set;
        if (wr_fire)
        begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= RESP_OK;
            if (aw_addr_reg == `PPW_PA_DATA_OFF)
                pa_data_reg <= lane0(pa_data_reg, w_data_reg, w_strb_reg);
            else if (aw_addr_reg == `PPW_PA_DIR_OFF)
                pa_dir_reg <= lane0(pa_dir_reg, w_data_reg, w_strb_reg);
            else if (aw_addr_reg == `PPW_PA_PULLUP_OFF)
                pa_pullup_reg <= lane0(pa_pullup_reg, w_data_reg, w_strb_reg);
            // software clears crystal pin enables here
            else if (aw_addr_reg == `PPW_PA_DIE_OFF)
                pa_die_reg <= lane0(pa_die_reg, w_data_reg, w_strb_reg);
            else if (aw_addr_reg == `PPW_PB_DATA_OFF)
                pb_data_reg <= lane0(pb_data_reg, w_data_reg, w_strb_reg);
            else if (aw_addr_reg == `PPW_PB_DIR_OFF)
                pb_dir_reg <= lane0(pb_dir_reg, w_data_reg, w_strb_reg);
            else if (aw_addr_reg == `PPW_PB_PULLUP_OFF)
                pb_pullup_reg <= lane0(pb_pullup_reg, w_data_reg, w_strb_reg);
            else if (aw_addr_reg == `PPW_PB_PULLDN_OFF)
                pb_pulldn_reg <= lane0(pb_pulldn_reg, w_data_reg, w_strb_reg)
                    & `PPW_PB_PULLDN_MASK;
            else if (aw_addr_reg == `PPW_PB_DIE_OFF)
                pb_die_reg <= lane0(pb_die_reg, w_data_reg, w_strb_reg);
            else if (aw_addr_reg == `PPW_WAKE_CFG_OFF)
                wake_cfg_reg <= w_strb_reg[0] ? w_data_reg[1:0] : wake_cfg_reg;
            else if (aw_addr_reg == `PPW_IRQ_CFG_OFF)
                irq_cfg_reg <= w_strb_reg[0] ? w_data_reg[3:0] : irq_cfg_reg;
            else if (aw_addr_reg == `PPW_IRQ_STAT_OFF)
                irq_stat_reg <= (irq_stat_reg & ~wr_byte[2:0]) | stat_set;
            else if (aw_addr_reg == `PPW_IRQ_MASK_OFF)
                irq_mask_reg <= w_strb_reg[0] ? w_data_reg[2:0] : irq_mask_reg;
            else if (aw_addr_reg != `PPW_PA_IN_OFF && aw_addr_reg != `PPW_PB_IN_OFF)
                s_axi_bresp <= RESP_SLVERR;
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite read channel

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= RESP_OK;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OK;
        s_axi_rdata <= 32'h00000000;
        if (s_axi_araddr == `PPW_PA_DATA_OFF)
            s_axi_rdata[7:0] <= pa_data_reg;
        else if (s_axi_araddr == `PPW_PA_DIR_OFF)
            s_axi_rdata[7:0] <= pa_dir_reg;
        else if (s_axi_araddr == `PPW_PA_PULLUP_OFF)
            s_axi_rdata[7:0] <= pa_pullup_reg;
        else if (s_axi_araddr == `PPW_PA_DIE_OFF)
            s_axi_rdata[7:0] <= pa_die_reg;
        else if (s_axi_araddr == `PPW_PA_IN_OFF)
            s_axi_rdata[7:0] <= pa_gated;
        else if (s_axi_araddr == `PPW_PB_DATA_OFF)
            s_axi_rdata[7:0] <= pb_data_reg;
        else if (s_axi_araddr == `PPW_PB_DIR_OFF)
            s_axi_rdata[7:0] <= pb_dir_reg;
        else if (s_axi_araddr == `PPW_PB_PULLUP_OFF)
            s_axi_rdata[7:0] <= pb_pullup_reg;
        else if (s_axi_araddr == `PPW_PB_PULLDN_OFF)
            s_axi_rdata[7:0] <= pb_pulldn_reg;
        else if (s_axi_araddr == `PPW_PB_DIE_OFF)
            s_axi_rdata[7:0] <= pb_die_reg;
        else if (s_axi_araddr == `PPW_PB_IN_OFF)
            s_axi_rdata[7:0] <= pb_gated;
        else if (s_axi_araddr == `PPW_WAKE_CFG_OFF)
            s_axi_rdata[1:0] <= wake_cfg_reg;
        else if (s_axi_araddr == `PPW_IRQ_CFG_OFF)
            s_axi_rdata[3:0] <= irq_cfg_reg;
        else if (s_axi_araddr == `PPW_IRQ_STAT_OFF)
            s_axi_rdata[2:0] <= irq_stat_reg;
        else if (s_axi_araddr == `PPW_IRQ_MASK_OFF)
            s_axi_rdata[2:0] <= irq_mask_reg;
        else
            s_axi_rresp <= RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// pad drive, registered so every output comes from a flop

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        pa_pad_out <= {PA_W{1'b0}};
        pa_pad_oe <= {PA_W{1'b0}};
        pa_pull_up <= {PA_W{1'b0}};
        pa_in_en <= {PA_W{1'b0}};
        pb_pad_out <= {PB_W{1'b0}};
        pb_pad_oe <= {PB_W{1'b0}};
        pb_pull_up <= {PB_W{1'b0}};
        pb_pull_dn <= {PB_W{1'b0}};
        pb_in_en <= {PB_W{1'b0}};
        irq <= 1'b0;
    end
    else
    begin
        pa_pad_out <= pa_data_reg & PA_IMPL;
        pa_pad_oe <= pa_dir_reg & PA_IMPL;
        pa_pad_out[`PPW_RSTPIN_BIT] <= 1'b0;
        pa_pad_oe[`PPW_RSTPIN_BIT] <= pa_dir_reg[`PPW_RSTPIN_BIT]
            & ~pa_data_reg[`PPW_RSTPIN_BIT];
        // pull-high not offered on the open-drain pin
        pa_pull_up <= pa_pullup_reg & PA_IMPL & ~pa_dir_reg;
        pa_pull_up[`PPW_RSTPIN_BIT] <= 1'b0;
        pa_in_en <= pa_die_reg & PA_IMPL;
        pb_pad_out <= pb_data_reg & PB_IMPL;
        pb_pad_oe <= pb_dir_reg & PB_IMPL;
        pb_pull_up <= pb_pullup_reg & PB_IMPL & ~pb_dir_reg;
        pb_pull_dn <= pb_pulldn_reg & PB_IMPL & ~pb_dir_reg;
        pb_in_en <= pb_die_reg & PB_IMPL;
        irq <= |(irq_stat_reg & irq_mask_reg);
    end
end

endmodule
`default_nettype wire

// *** ppw_top_bench.sv ***
// Purpose: self-checking bench for the port pin wake-up block
// Assumes: 125 MHz aclk, short wake counts 8 and 2
// Notes: one task per scenario
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end

module ppw_top_bench;
    logic aclk = 0, aresetn = 0, alt0 = 0, alt1 = 0, sleep = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, pa_ext = 0, pb_ext = 0;
    logic [31:0] wdata = 0, rd;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] rr, br;
    wire wake_req, irq, awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] pa_out, pa_oe, pa_pu, pa_ie, pa_in, pb_out, pb_oe, pb_pu, pb_pd, pb_ie, pb_in;
    int failures = 0, samples_checked = 0;

    ppw_top #(.WAKE_NORM_CYC(16'd8), .WAKE_FAST_CYC(16'd2)) u_dut (.aclk(aclk),
        .aresetn(aresetn), .irq0_alt_sel(alt0), .irq1_alt_sel(alt1), .sleep_active(sleep),
        .wake_req(wake_req), .pa_pad_in(pa_in), .pa_pad_out(pa_out), .pa_pad_oe(pa_oe),
        .pa_pull_up(pa_pu), .pa_in_en(pa_ie), .pb_pad_in(pb_in), .pb_pad_out(pb_out),
        .pb_pad_oe(pb_oe), .pb_pull_up(pb_pu), .pb_pull_dn(pb_pd), .pb_in_en(pb_ie),
        .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    ppw_pads u_pa (.aclk(aclk), .pad_out(pa_out), .pad_oe(pa_oe), .pull_up(pa_pu),
        .pull_dn(8'h00), .ext_val(pa_ext), .ext_en(8'hff), .pad_in(pa_in));
    ppw_pads u_pb (.aclk(aclk), .pad_out(pb_out), .pad_oe(pb_oe), .pull_up(pb_pu),
        .pull_dn(pb_pd), .ext_val(pb_ext), .ext_en(8'hff), .pad_in(pb_in));

    initial
        forever #4 aclk = ~aclk;

    ////////////////////////////////////////////////////////////////
    task tally_and_finish;
        if (failures == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task hang;
        failures++;
        tally_and_finish();
    endtask
    task do_reset;
        aresetn <= 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
    endtask
    // both channels offered together, each dropped once taken
    task wr(input [7:0] a, input [7:0] d);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (n = 0; n < 20 && !bvalid; n++)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end
        br = bresp;
        bready <= 0;
        if (n == 20) hang();
    endtask
    task rdw(input [7:0] a);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        for (n = 0; n < 20 && !rvalid; n++)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end
        rd = rdata;
        rr = rresp;
        rready <= 0;
        if (n == 20) hang();
    endtask
    task rdchk(input [7:0] a, input [7:0] e, input string nm);
        rdw(a);
        `CHK(nm, {24'h0, e}, rd)
    endtask
    // drives the pins of both external lines together
    task set_pin(input logic alt, input logic v);
        @(posedge aclk);
        if (alt)
        begin
            pb_ext[5] <= v;
            pa_ext[4] <= v;
        end
        else
        begin
            pa_ext[0] <= v;
            pb_ext[0] <= v;
        end
    endtask

    ////////////////////////////////////////////////////////////////
    task t_reset;
        rdchk(8'h0c, 8'hff, "pa_die");
        rdchk(8'h24, 8'hff, "pb_die");
        `CHK("pa_in_en", 8'hf9, pa_ie)
        `CHK("pb_in_en", 8'hff, pb_ie)
        wr(8'h3c, 8'h00);
        `CHK("unmapped_wr", 2'b10, br)
        rdw(8'h3c);
        `CHK("unmapped", 2'b10, rr)
    endtask
    task t_drive;
        wr(8'h04, 8'h21);
        wr(8'h08, 8'h09);
        wr(8'h00, 8'h21);
        wr(8'h20, 8'hff);
        wr(8'h18, 8'h81);
        wr(8'h14, 8'h80);
        wr(8'h1c, 8'h03);
        repeat (2) @(posedge aclk);
        `CHK("od_release", 8'h01, pa_oe)
        `CHK("pa_out", 8'h01, pa_out & 8'h21)
        `CHK("pa_pull", 8'h08, pa_pu)
        `CHK("pb_pull_dn", 8'h40, pb_pd)
        `CHK("pb_out", 8'h80, pb_out)
        `CHK("pb_pull", 8'h02, pb_pu)
        wr(8'h00, 8'h00);
        repeat (2) @(posedge aclk);
        `CHK("od_low", 8'h21, pa_oe)
        wr(8'h04, 8'h00);
        wr(8'h20, 8'h00);
        wr(8'h18, 8'h00);
        wstrb <= 4'h0;
        wr(8'h00, 8'hff);
        wstrb <= 4'hf;
        rdchk(8'h00, 8'h00, "strb_off");
    endtask
    task t_die;
        wr(8'h0c, 8'h3f);
        @(posedge aclk);
        pa_ext <= 8'hd0;
        repeat (6) @(posedge aclk);
        `CHK("pa_in_en", 8'h39, pa_ie)
        rdchk(8'h10, 8'h10, "pa_input");
    endtask
    // every edge mode, each with a mask check after the rise
    task t_irq(input logic alt);
        int m;
        for (m = 1; m < 4; m++)
        begin
            wr(8'h30, 8'(m * 5));
            wr(8'h38, 8'h03);
            set_pin(alt, 1);
            repeat (8) @(posedge aclk);
            `CHK("irq_rise", m[0], irq)
            rdchk(8'h34, {6'h0, m[0], m[0]}, "stat_rise");
            wr(8'h38, 8'h00);
            @(posedge aclk);
            `CHK("irq_masked", 1'b0, irq)
            wr(8'h34, 8'h07);
            wr(8'h38, 8'h03);
            set_pin(alt, 0);
            repeat (8) @(posedge aclk);
            `CHK("irq_fall", m[1], irq)
            rdchk(8'h34, {6'h0, m[1], m[1]}, "stat_fall");
            wr(8'h34, 8'h07);
        end
    endtask
    task wake_time(output int c);
        @(posedge aclk);
        sleep <= 1;
        @(posedge aclk);
        pa_ext[4] <= ~pa_ext[4];
        for (c = 0; c < 60 && wake_req !== 1'b1; c++) @(posedge aclk);
        if (c == 60) hang();
        sleep <= 0;
        repeat (2) @(posedge aclk);
        `CHK("wake_drop", 1'b0, wake_req)
    endtask
    task t_wake;
        int cf, cn;
        wr(8'h0c, 8'h7f);
        wr(8'h2c, 8'h03);
        @(posedge aclk);
        sleep <= 1;
        pa_ext[7] <= ~pa_ext[7];
        repeat (30) @(posedge aclk);
        `CHK("wake_gated", 1'b0, wake_req)
        wake_time(cf);
        rdchk(8'h34, 8'h06, "wake_stat");
        wr(8'h2c, 8'h01);
        wake_time(cn);
        `CHK("wake_gap", 6, cn - cf)
    endtask

    ////////////////////////////////////////////////////////////////
    initial
    begin
        do_reset();
        t_reset();
        t_drive();
        t_die();
        t_irq(1'b0);
        alt0 <= 1;
        alt1 <= 1;
        pa_ext <= 8'h00;
        do_reset();
        t_irq(1'b1);
        t_wake();
        tally_and_finish();
    end
endmodule
`default_nettype wire
